// ==== dv/lfl_mcu.sv ====
// Partner: management controller that pulses the shutdown pin.
// Assumes requests arrive as one-cycle start pulses on mclk.
`timescale 1ns/1ps
module lfl_mcu (
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       start,
  input  wire logic [7:0] hold,
  output logic            shutdown_input,
  output logic            busy
);
  logic [7:0] left;
  initial shutdown_input = 1'b1;
  initial busy = 1'b0;
  initial left = 8'h00;
  // Pin stays disabling after reset until the first request's hold count runs out
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      shutdown_input <= 1'b1;
      left <= 8'h00;
      busy <= 1'b0;
    end else if (start) begin
      shutdown_input <= 1'b1;
      left <= hold;
      busy <= 1'b1;
    end else if (left > 8'h01) left <= left - 8'h01;
    else if (left == 8'h01) begin
      left <= 8'h00;
      shutdown_input <= 1'b0;
      busy <= 1'b0;
    end
  end
endmodule

// ==== dv/lfl_top_props.sv ====
// Checker: timing relations on the fault latch top-level ports.
// Assumes one mclk domain and an async active-low resetn.
`timescale 1ns/1ps
module lfl_top_props #(
  parameter int BIAS_W = 10,
  parameter int MOD_W  = 8,
  parameter int PD_W   = 10
) (
  input wire logic              mclk,
  input wire logic              resetn,
  input wire logic [3:0]        reg_addr,
  input wire logic [15:0]       reg_wdata,
  input wire logic              reg_write,
  input wire logic              reg_read,
  input wire logic [15:0]       reg_rdata,
  input wire logic              shutdown_input,
  input wire logic              monitor_over_ref,
  input wire logic [PD_W-1:0]   pd_current,
  input wire logic              fault_output,
  input wire logic [BIAS_W-1:0] bias_drive,
  input wire logic [MOD_W-1:0]  mod_drive,
  input wire logic              mod_range_100ma,
  input wire logic              termination_high,
  input wire logic              crosspoint_positive,
  input wire logic [6:0]        crosspoint_magnitude,
  input wire logic              limiter_decrease,
  input wire logic [2:0]        limiter_trim_magnitude,
  input wire logic              limiter_adjust_active
);
  // ==========================================================
  // Control shadow; quiet_cnt at 15 means the pin synchroniser has settled low
  logic [3:0] quiet_cnt;
  logic       fen_q;
  logic       en_q;
  wire        ctrl_wr = reg_write && reg_addr == lfl_pkg::REG_CTRL;
  wire        trim_wr = reg_write && reg_addr == lfl_pkg::REG_TRIM;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      quiet_cnt <= 4'h0;
      fen_q     <= lfl_pkg::CTRL_RESET[1];
      en_q      <= lfl_pkg::CTRL_RESET[0];
    end else begin
      quiet_cnt <= (shutdown_input || ctrl_wr) ? 4'h0 : quiet_cnt + {3'h0, quiet_cnt != 4'hF};
      if (ctrl_wr) begin
        fen_q <= reg_wdata[1];
        en_q  <= reg_wdata[0];
      end
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // ==========================================================
  // Properties
  // Trim outputs lag a write by two edges: field register, then output flop
  property p_cp;
    trim_wr |-> ##2 crosspoint_positive == $past(reg_wdata[15], 2)
      && crosspoint_magnitude == $past(reg_wdata[14:8], 2);
  endproperty
  a_cp: assert property (p_cp)
    else $error("crosspoint fields wrong");
  property p_lim;
    trim_wr |-> ##2 {limiter_decrease, limiter_trim_magnitude} == $past(reg_wdata[3:0], 2)
      && limiter_adjust_active == ($past(reg_wdata[2:0], 2) != 3'h0);
  endproperty
  a_lim: assert property (p_lim)
    else $error("limiter fields wrong");
  property p_term;
    trim_wr |-> ##2 {termination_high, mod_range_100ma} == $past(reg_wdata[1:0], 2);
  endproperty
  a_term: assert property (p_term)
    else $error("termination or range bit wrong");
  property p_zero; fault_output |-> bias_drive == '0 && mod_drive == '0; endproperty
  a_zero: assert property (p_zero)
    else $error("drives not zero in fault");
  property p_latch; quiet_cnt == 4'hF && en_q && fault_output |=> fault_output; endproperty
  a_latch: assert property (p_latch)
    else $error("fault output not latched");
  property p_release; shutdown_input [*8] |-> !fault_output; endproperty
  a_release: assert property (p_release)
    else $error("fault output held while disabled");
  property p_gated; $rose(fault_output) |-> $past(fen_q) || $past(fen_q, 2); endproperty
  a_gated: assert property (p_gated)
    else $error("fault latched with fault enable clear");
  property p_detect;
    monitor_over_ref && fen_q && en_q && quiet_cnt == 4'hF |-> ##[1:8] fault_output;
  endproperty
  a_detect: assert property (p_detect)
    else $error("monitor fault not taken");
endmodule

bind lfl_top lfl_top_props #(.BIAS_W(BIAS_W), .MOD_W(MOD_W), .PD_W(PD_W)) lfl_top_props_inst (
  .mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .shutdown_input(shutdown_input), .monitor_over_ref(monitor_over_ref),
  .pd_current(pd_current), .fault_output(fault_output), .bias_drive(bias_drive),
  .mod_drive(mod_drive), .mod_range_100ma(mod_range_100ma),
  .termination_high(termination_high), .crosspoint_positive(crosspoint_positive),
  .crosspoint_magnitude(crosspoint_magnitude), .limiter_decrease(limiter_decrease),
  .limiter_trim_magnitude(limiter_trim_magnitude),
  .limiter_adjust_active(limiter_adjust_active));

// ==== dv/testbench.sv ====
// Bench: drives registers, pins and the controller model; judges outputs.
// Assumes default lfl_top widths and the lfl_mcu partner.
`timescale 1ns/1ps
module testbench;
  logic        mclk = 1'b0;
  logic        resetn = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic        monitor_over_ref = 1'b0;
  logic [9:0]  pd_current = 10'h100;
  logic        start = 1'b0;
  logic [7:0]  hold = 8'h00;
  logic [15:0] reg_rdata, rd_val;
  logic [9:0]  bias_drive;
  logic [7:0]  mod_drive;
  logic [6:0]  cp_mag;
  logic [2:0]  lim_mag;
  logic        shutdown_input, busy, fault_output, cp_pos, lim_dec, lim_act, term_hi, rng_hi;
  int          err_count = 0;
  int          num_checks = 0;
  always #12.5 mclk = ~mclk;
  lfl_mcu lfl_mcu_inst (.mclk(mclk), .resetn(resetn), .start(start), .hold(hold),
    .shutdown_input(shutdown_input), .busy(busy));
  lfl_top lfl_top_inst (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .shutdown_input(shutdown_input), .monitor_over_ref(monitor_over_ref),
    .pd_current(pd_current), .fault_output(fault_output), .bias_drive(bias_drive),
    .mod_drive(mod_drive), .mod_range_100ma(rng_hi), .termination_high(term_hi),
    .crosspoint_positive(cp_pos), .crosspoint_magnitude(cp_mag), .limiter_decrease(lim_dec),
    .limiter_trim_magnitude(lim_mag), .limiter_adjust_active(lim_act));
  // ==========================================================
  // Shared tasks
  task automatic wrap_up;
    if (err_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Trailing idle edge keeps back-to-back writes from assigning the strobe twice
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [3:0] a);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge mclk);
    reg_read <= 1'b0;
    @(posedge mclk);
    rd_val = reg_rdata;
  endtask
  task automatic wait_fault;
    for (int i = 0; i < 12 && fault_output !== 1'b1; i++) @(posedge mclk);
  endtask
  task automatic recover_pin(input int n);
    hold <= 8'(n);
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    repeat (20) @(posedge mclk);
    chk(fault_output, 16'h0);
    for (int i = 0; i < 100 && busy; i++) @(posedge mclk);
  endtask
  task automatic check_run;
    repeat (lfl_pkg::NEGATE_CYC + 20) @(posedge mclk);
    chk(bias_drive, 16'h0200);
    chk(mod_drive, 16'h0040);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    rd(lfl_pkg::REG_CTRL);
    chk(rd_val, 16'h0003);
    wr(4'hF, 16'hFFFF);
    rd(4'hF);
    chk(rd_val, 16'h0000);
    chk(bias_drive, 16'h0000);
  endtask
  task automatic t_trim;
    logic [15:0] tv [5] = '{16'hFF0F, 16'h0000, 16'h7F06, 16'h8001, 16'h0008};
    foreach (tv[i]) begin
      wr(lfl_pkg::REG_TRIM, tv[i]);
      // Decoded outputs are flopped once more after the field register
      @(posedge mclk);
      chk({cp_pos, cp_mag}, tv[i][15:8]);
      chk({lim_dec, lim_mag}, tv[i][3:0]);
      chk(lim_act, tv[i][2:0] != 3'h0);
      chk({term_hi, rng_hi}, tv[i][1:0]);
    end
  endtask
  task automatic t_faults;
    pd_current <= 10'h180;
    wr(lfl_pkg::REG_BIAS, 16'h0100);
    wr(lfl_pkg::REG_BIAS, 16'h0200);
    repeat (12) @(posedge mclk);
    chk(fault_output, 16'h0);
    for (int k = 0; k < 3; k++) begin
      if (k == 0) monitor_over_ref <= 1'b1;
      if (k == 1) pd_current <= 10'h181;
      if (k == 2) wr(lfl_pkg::REG_BIAS, 16'h00FF);
      wait_fault();
      chk(fault_output, 16'h1);
      chk(bias_drive, 16'h0);
      chk(mod_drive, 16'h0);
      monitor_over_ref <= 1'b0;
      pd_current <= 10'h100;
      if (k == 2) wr(lfl_pkg::REG_BIAS, 16'h0200);
      repeat (20) @(posedge mclk);
      chk(fault_output, 16'h1);
      if (k == 1) begin
        wr(lfl_pkg::REG_CTRL, 16'h0002);
        repeat (20) @(posedge mclk);
        chk(fault_output, 16'h0);
        repeat (25) @(posedge mclk);
        wr(lfl_pkg::REG_CTRL, 16'h0003);
      end else recover_pin(lfl_pkg::LATCH_RESET_CYC + 5);
      repeat (10) @(posedge mclk);
      chk(bias_drive, 16'h0);
      check_run();
    end
  endtask
  task automatic t_persist;
    monitor_over_ref <= 1'b1;
    wait_fault();
    recover_pin(lfl_pkg::LATCH_RESET_CYC + 5);
    wait_fault();
    chk(fault_output, 16'h1);
    chk(bias_drive, 16'h0);
    // Status: fault condition, pin seen low, state latched
    rd(lfl_pkg::REG_STATUS);
    chk(rd_val, 16'h0009);
    monitor_over_ref <= 1'b0;
    recover_pin(lfl_pkg::LATCH_RESET_CYC + 5);
    check_run();
  endtask
  task automatic t_fen_off;
    wr(lfl_pkg::REG_CTRL, 16'h0001);
    monitor_over_ref <= 1'b1;
    repeat (20) @(posedge mclk);
    chk(fault_output, 16'h0);
    chk(bias_drive, 16'h0200);
    monitor_over_ref <= 1'b0;
    repeat (4) @(posedge mclk);
    wr(lfl_pkg::REG_CTRL, 16'h0003);
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    wrap_up();
  end
  initial begin
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_trim();
    wr(lfl_pkg::REG_BIAS, 16'h0200);
    wr(lfl_pkg::REG_MOD, 16'h0040);
    wr(lfl_pkg::REG_PD_SET, 16'h0100);
    recover_pin(1);
    check_run();
    t_faults();
    t_persist();
    t_fen_off();
    wrap_up();
  end
endmodule

// ==== rtl/lfl_detect.sv ====
// Fault condition detection: comparator, photodiode overcurrent, bias step.
// Assumes the comparator input is already synchronised to mclk.
`timescale 1ns/1ps
module lfl_detect #(
  parameter int BIAS_W = 10,
  parameter int PD_W   = 10
) (
  input  wire logic              mclk,
  input  wire logic              resetn,
  input  wire logic              monitor_over_ref,
  input  wire logic [PD_W-1:0]   pd_current,
  input  wire logic [PD_W-1:0]   pd_set,
  input  wire logic [BIAS_W-1:0] bias_dac_code,
  input  wire logic              bias_update,
  output logic                   fault_cond
);
  logic [BIAS_W-1:0] prev_bias;
  logic              step_fault;
  logic [PD_W+1:0]   pd_x2;
  logic [PD_W+1:0]   pd_set_x3;
  logic              pd_over;
  logic              bias_drop;
  // Compare 2*I against 3*set to test I > 1.5*set without fractions
  assign pd_x2     = {1'b0, pd_current, 1'b0};
  assign pd_set_x3 = {2'b00, pd_set} + {1'b0, pd_set, 1'b0};
  assign pd_over   = pd_x2 > pd_set_x3;
  // New code below half of the old one means it dropped by more than half
  assign bias_drop = ({bias_dac_code, 1'b0} < {1'b0, prev_bias});
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      prev_bias  <= '0;
      step_fault <= 1'b0;
    end else if (bias_update) begin
      prev_bias  <= bias_dac_code;
      step_fault <= bias_drop;
    end
  end
  // Step fault holds until the next update so the latch can see it
  assign fault_cond = monitor_over_ref | pd_over | step_fault;
endmodule

// ==== rtl/lfl_pkg.sv ====
// Package for the laser fault latch and trim field decoder.
// Assumes a 40 MHz mclk and a word-wide register port in the top level.
package lfl_pkg;
  // ==========================================================
  // Register offsets (word index on the plain register port)
  localparam logic [3:0] REG_CTRL      = 4'h0;
  localparam logic [3:0] REG_TRIM      = 4'h1;
  localparam logic [3:0] REG_BIAS      = 4'h2;
  localparam logic [3:0] REG_MOD       = 4'h3;
  localparam logic [3:0] REG_PD_SET    = 4'h4;
  localparam logic [3:0] REG_STATUS    = 4'h5;
  // ==========================================================
  // CTRL fields
  localparam int CTRL_ENABLE_BIT       = 0;
  localparam int CTRL_FAULT_EN_BIT     = 1;
  // TRIM fields
  localparam int TRIM_RANGE_EXT_BIT    = 0;
  localparam int TRIM_TERM_BOOST_BIT   = 1;
  localparam int TRIM_LIM_MAG_LSB      = 0;
  localparam int TRIM_LIM_SIGN_BIT     = 3;
  localparam int TRIM_CP_MAG_LSB       = 0;
  localparam int TRIM_CP_SIGN_BIT      = 7;
  // ==========================================================
  // Reset values
  localparam logic [7:0] CTRL_RESET    = 8'h03;
  localparam logic [7:0] TRIM_RESET    = 8'h00;
  // ==========================================================
  // Modulation current limits in mA
  localparam int MOD_LIMIT_NORMAL_MA   = 80;
  localparam int MOD_LIMIT_EXTEND_MA   = 100;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_PS         = 25000;
  localparam int LATCH_RESET_TIME_NS   = 1000;
  localparam int NEGATE_TIME_NS        = 1000;
  localparam int LATCH_RESET_CYC =
    (LATCH_RESET_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int NEGATE_CYC =
    (NEGATE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  typedef enum logic [1:0] {
    LFL_RUN,
    LFL_FAULT,
    LFL_CLEAR,
    LFL_WAKE
  } lfl_state_t;
endpackage

// ==== rtl/lfl_sync.sv ====
// Three-stage synchroniser with agreement filter for one pin input.
// Assumes the pin is asynchronous to mclk.
`timescale 1ns/1ps
module lfl_sync #(
  parameter logic RESET_VALUE = 1'b0
) (
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic pin,
  output logic      level
);
  logic s1;
  logic s2;
  logic s3;
  // A change counts once the second and third stages agree
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s1    <= RESET_VALUE;
      s2    <= RESET_VALUE;
      s3    <= RESET_VALUE;
      level <= RESET_VALUE;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end
endmodule

// ==== rtl/lfl_top.sv ====
// Laser driver control: trim field decoding and laser safety fault latch.
// Assumes a 40 MHz mclk, async active-low resetn and a plain register port.
// Overview of operation
// - Cross-point magnitude all ones gives largest shift, all zeros smallest.
// - Cross-point sign one shifts positive, zero shifts negative.
// - Limiter trim sign one lowers limiter bias, zero raises it.
// - Limiter magnitude zero leaves current unchanged, all ones largest change.
// - Termination boost bit 1 selects high termination current.
// - Modulation range bit 1 allows 100 mA, else limit to 80 mA.
// - Bias monitor above reference raises a fault condition.
// - Photodiode current above 150 percent of set raises a fault.
// - Bias code dropping by more than half in one step raises a fault.
// - Fault conditions act only while fault enable is one.
// - Enabled fault forces bias and modulation currents to zero.
// - Enabled fault asserts and latches the fault output.
// - Fault output released while shutdown asserted or enable cleared.
// - Clean re-enable from a latched fault resumes prior settings after the negate time.
// - Persisting fault on re-enable reasserts fault, outputs stay off.
`timescale 1ns/1ps
module lfl_top #(
  parameter int BIAS_W = 10,
  parameter int MOD_W  = 8,
  parameter int PD_W   = 10
) (
  input  wire logic              mclk,
  input  wire logic              resetn,
  input  wire logic [3:0]        reg_addr,
  input  wire logic [15:0]       reg_wdata,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output logic [15:0]            reg_rdata,
  input  wire logic              shutdown_input,
  input  wire logic              monitor_over_ref,
  input  wire logic [PD_W-1:0]   pd_current,
  output logic                   fault_output,
  output logic [BIAS_W-1:0]      bias_drive,
  output logic [MOD_W-1:0]       mod_drive,
  output logic                   mod_range_100ma,
  output logic                   termination_high,
  output logic                   crosspoint_positive,
  output logic [6:0]             crosspoint_magnitude,
  output logic                   limiter_decrease,
  output logic [2:0]             limiter_trim_magnitude,
  output logic                   limiter_adjust_active
);
  // ==========================================================
  // Register storage
  logic [7:0]        ctrl;
  logic [7:0]        trim_lo;
  logic [7:0]        trim_cp;
  logic [BIAS_W-1:0] bias_dac_code;
  logic [MOD_W-1:0]  modulation_dac_code;
  logic [PD_W-1:0]   pd_set;
  logic              bias_update;
  logic              internal_enable_bit;
  logic              fault_response_enable;
  logic              limiter_trim_sign;
  logic              crosspoint_sign;
  logic              termination_boost_enable;
  logic              modulation_range_extend;

  wire wr_ctrl = reg_write && (reg_addr == lfl_pkg::REG_CTRL);
  wire wr_trim = reg_write && (reg_addr == lfl_pkg::REG_TRIM);
  wire wr_bias = reg_write && (reg_addr == lfl_pkg::REG_BIAS);
  wire wr_mod  = reg_write && (reg_addr == lfl_pkg::REG_MOD);
  wire wr_pd   = reg_write && (reg_addr == lfl_pkg::REG_PD_SET);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl                <= lfl_pkg::CTRL_RESET;
      trim_lo             <= lfl_pkg::TRIM_RESET;
      trim_cp             <= lfl_pkg::TRIM_RESET;
      bias_dac_code       <= '0;
      modulation_dac_code <= '0;
      pd_set              <= '0;
      bias_update         <= 1'b0;
    end else begin
      bias_update <= wr_bias;
      if (wr_ctrl) begin
        ctrl <= reg_wdata[7:0];
      end
      if (wr_trim) begin
        trim_lo <= reg_wdata[7:0];
        trim_cp <= reg_wdata[15:8];
      end
      if (wr_bias) begin
        bias_dac_code <= reg_wdata[BIAS_W-1:0];
      end
      if (wr_mod) begin
        modulation_dac_code <= reg_wdata[MOD_W-1:0];
      end
      if (wr_pd) begin
        pd_set <= reg_wdata[PD_W-1:0];
      end
    end
  end

  assign internal_enable_bit   = ctrl[lfl_pkg::CTRL_ENABLE_BIT];
  assign fault_response_enable = ctrl[lfl_pkg::CTRL_FAULT_EN_BIT];

  // ==========================================================
  // Trim field decoding
  assign crosspoint_sign          = trim_cp[lfl_pkg::TRIM_CP_SIGN_BIT];
  assign limiter_trim_sign        = trim_lo[lfl_pkg::TRIM_LIM_SIGN_BIT];
  assign termination_boost_enable = trim_lo[lfl_pkg::TRIM_TERM_BOOST_BIT];
  assign modulation_range_extend  = trim_lo[lfl_pkg::TRIM_RANGE_EXT_BIT];

  logic [7:0] trim_lim_bits;
  assign trim_lim_bits = trim_lo >> lfl_pkg::TRIM_LIM_MAG_LSB;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      crosspoint_positive    <= 1'b0;
      crosspoint_magnitude   <= '0;
      limiter_decrease       <= 1'b0;
      limiter_trim_magnitude <= '0;
      limiter_adjust_active  <= 1'b0;
      termination_high       <= 1'b0;
      mod_range_100ma        <= 1'b0;
    end else begin
      // Magnitude is passed straight: 7F is the largest shift either way
      crosspoint_magnitude   <= trim_cp[6:0];
      crosspoint_positive    <= crosspoint_sign;
      limiter_decrease       <= limiter_trim_sign;
      limiter_trim_magnitude <= trim_lim_bits[2:0];
      // Zero magnitude means no trim regardless of sign
      limiter_adjust_active  <= |trim_lim_bits[2:0];
      termination_high       <= termination_boost_enable;
      mod_range_100ma        <= modulation_range_extend;
    end
  end

  // ==========================================================
  // Fault detection
  logic shutdown_level;
  logic fault_cond;

  lfl_sync #(
    .RESET_VALUE (1'b1)
  ) u_shutdown_sync (
    .mclk   (mclk),
    .resetn (resetn),
    .pin    (shutdown_input),
    .level  (shutdown_level)
  );

  lfl_detect #(
    .BIAS_W (BIAS_W),
    .PD_W   (PD_W)
  ) u_detect (
    .mclk             (mclk),
    .resetn           (resetn),
    .monitor_over_ref (monitor_over_ref),
    .pd_current       (pd_current),
    .pd_set           (pd_set),
    .bias_dac_code    (bias_dac_code),
    .bias_update      (bias_update),
    .fault_cond       (fault_cond)
  );

  // ==========================================================
  // Fault latch and recovery
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] LATCH_CYC  = CNT_W'(lfl_pkg::LATCH_RESET_CYC);
  localparam logic [CNT_W-1:0] NEGATE_CYC = CNT_W'(lfl_pkg::NEGATE_CYC);

  lfl_pkg::lfl_state_t state;
  lfl_pkg::lfl_state_t next_state;
  logic [CNT_W-1:0]    timer;
  logic [CNT_W-1:0]    next_timer;
  logic                disabled;
  logic                enabled_fault;

  assign disabled      = shutdown_level || !internal_enable_bit;
  assign enabled_fault = fault_cond && fault_response_enable;

  always_comb begin
    next_state = state;
    next_timer = (timer == '1) ? timer : timer + CNT_W'(1);
    unique case (state)
      lfl_pkg::LFL_RUN: begin
        next_timer = '0;
        if (enabled_fault && !disabled) begin
          next_state = lfl_pkg::LFL_FAULT;
        end
      end
      lfl_pkg::LFL_FAULT: begin
        next_timer = '0;
        if (disabled) begin
          next_state = lfl_pkg::LFL_CLEAR;
        end
      end
      lfl_pkg::LFL_CLEAR: begin
        // A short disable pulse does not clear the latch
        if (!disabled) begin
          next_timer = '0;
          if (timer >= LATCH_CYC) begin
            next_state = enabled_fault ? lfl_pkg::LFL_FAULT
                                       : lfl_pkg::LFL_WAKE;
          end else begin
            next_state = lfl_pkg::LFL_FAULT;
          end
        end
      end
      lfl_pkg::LFL_WAKE: begin
        if (disabled) begin
          next_state = lfl_pkg::LFL_CLEAR;
          next_timer = '0;
        end else if (enabled_fault) begin
          next_state = lfl_pkg::LFL_FAULT;
        end else if (timer >= NEGATE_CYC - CNT_W'(1)) begin
          next_state = lfl_pkg::LFL_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state <= lfl_pkg::LFL_RUN;
      timer <= '0;
    end else begin
      state <= next_state;
      timer <= next_timer;
    end
  end

  // ==========================================================
  // Output drive
  logic outputs_on;
  logic latched;
  assign latched    = (state == lfl_pkg::LFL_FAULT);
  // Settings registers are untouched by a fault, so recovery restores them
  assign outputs_on = (state == lfl_pkg::LFL_RUN) && !disabled;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      fault_output <= 1'b0;
      bias_drive   <= '0;
      mod_drive    <= '0;
    end else begin
      fault_output <= latched && !disabled;
      bias_drive   <= outputs_on ? bias_dac_code : '0;
      mod_drive    <= outputs_on ? modulation_dac_code : '0;
    end
  end

  // ==========================================================
  // Read port
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    unique case (reg_addr)
      lfl_pkg::REG_CTRL:   rd_mux = {8'h00, ctrl};
      lfl_pkg::REG_TRIM:   rd_mux = {trim_cp, trim_lo};
      lfl_pkg::REG_BIAS:   rd_mux = 16'(bias_dac_code);
      lfl_pkg::REG_MOD:    rd_mux = 16'(modulation_dac_code);
      lfl_pkg::REG_PD_SET: rd_mux = 16'(pd_set);
      lfl_pkg::REG_STATUS: rd_mux = {12'h000, fault_cond, shutdown_level, state};
      default:             rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= reg_read ? rd_mux : 16'h0000;
    end
  end
endmodule
